// ### rtl/mrp_pkg.sv
// package: constants, register map and types of the memory region protection unit
//
// Notes on behaviour
// - protection off: default map applies, no fault is ever raised
// - protection on: violating an enabled matching region raises a fault
// - privileged-default option: privileged access hitting no region uses default map
// - protection on, no option, no enabled region: accesses fault
// - fault-handler option keeps checks in hard fault/NMI, else default map
// - a readable register reports the total number of regions supported
// - eight independently configurable regions are provided
// - disabling a region keeps base, size and permissions for re-enable
// - an enabled region applies its permissions; violations fault
// - size code encodes 32 bytes up to 4 GB, one code per doubling
// - execute-never bit set: fetches fault, data accesses unaffected
// - six read/write combinations, checked separately for privileged and user
// - eight equal sub-regions each with a disable bit excluding it from match
// - sub-region disables apply only to regions of 256 bytes or more
// - address in disabled sub-region is treated as outside that region
// - enable bit is written together with the region attributes
// - region readback returns base, attributes and enable in writable form
package mrp_pkg;

  localparam int unsigned MRP_REGIONS = 8;

  // register byte offsets
  localparam logic [11:0] MRP_OFF_CTRL = 12'h000;
  localparam logic [11:0] MRP_OFF_COUNT = 12'h004;
  localparam logic [11:0] MRP_OFF_SELECT = 12'h008;
  localparam logic [11:0] MRP_OFF_BASE = 12'h00C;
  localparam logic [11:0] MRP_OFF_ATTR = 12'h010;
  localparam logic [11:0] MRP_OFF_STATUS = 12'h014;
  localparam logic [11:0] MRP_OFF_FADDR = 12'h018;

  // control register fields
  localparam int unsigned MRP_CTRL_ENABLE_BIT = 0;
  localparam int unsigned MRP_CTRL_PRIVDEF_BIT = 1;
  localparam int unsigned MRP_CTRL_HFNMI_BIT = 2;

  // attribute register fields
  localparam int unsigned MRP_ATTR_ACTIVE_BIT = 0;
  localparam int unsigned MRP_ATTR_SIZE_LSB = 1;
  localparam int unsigned MRP_ATTR_SUB_LSB = 8;
  localparam int unsigned MRP_ATTR_PERM_LSB = 24;
  localparam int unsigned MRP_ATTR_XN_BIT = 28;

  // size code n gives 2^(n+1) bytes: 4 is 32 bytes, 31 is 4 GB
  localparam logic [4:0] MRP_SIZE_MIN = 5'h04;
  localparam logic [4:0] MRP_SIZE_MAX = 5'h1F;
  localparam logic [4:0] MRP_SIZE_SUB_MIN = 5'h07;
  localparam logic [4:0] MRP_SIZE_RESET = 5'h04;

  // read/write permission codes, privileged then user
  localparam logic [2:0] MRP_PERM_NO_NO = 3'h0;
  localparam logic [2:0] MRP_PERM_RW_NO = 3'h1;
  localparam logic [2:0] MRP_PERM_RW_RO = 3'h2;
  localparam logic [2:0] MRP_PERM_RW_RW = 3'h3;
  localparam logic [2:0] MRP_PERM_RO_NO = 3'h5;
  localparam logic [2:0] MRP_PERM_RO_RO = 3'h6;

  typedef struct packed {
    logic [31:0] base;
    logic [4:0] size;
    logic [7:0] sub_off;
    logic [2:0] perm;
    logic exec_forbidden;
    logic active;
  } mrp_region_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic write;
    logic fetch;
    logic priv;
    logic handler;
  } mrp_access_t;

  typedef struct packed {
    logic enable;
    logic privileged_default_map_option;
    logic fault_handler_protect_option;
  } mrp_ctrl_t;

  typedef enum logic [1:0] {
    MRP_RES_DEFAULT,
    MRP_RES_REGION,
    MRP_RES_FAULT
  } mrp_result_t;

endpackage

// ### rtl/mrp_region_match.sv
// one region's address match and permission evaluation
`timescale 1ns/1ps
module mrp_region_match (
  input wire mrp_pkg::mrp_region_t region,
  input wire mrp_pkg::mrp_access_t acc,
  output logic hit,
  output logic allowed
);

  logic [31:0] mask;
  logic [2:0] sub_idx;
  logic sub_disabled;
  logic rd_ok;
  logic wr_ok;

  always_comb begin
    mask = ~((32'h0000_0002 << region.size) - 32'h0000_0001);
    if (region.size == mrp_pkg::MRP_SIZE_MAX) begin
      mask = 32'h0000_0000;
    end
    // eighth of region selected by top three in-region bits
    sub_idx = 3'(acc.addr >> (region.size - 5'h02));
    sub_disabled = (region.size >= mrp_pkg::MRP_SIZE_SUB_MIN) && region.sub_off[sub_idx];
    // inactive region keeps its fields but never hits
    hit = region.active && ((acc.addr & mask) == (region.base & mask)) && !sub_disabled;
    // privileged and user rights checked separately
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    case (region.perm)
      mrp_pkg::MRP_PERM_RW_NO: begin
        rd_ok = acc.priv;
        wr_ok = acc.priv;
      end
      mrp_pkg::MRP_PERM_RW_RO: begin
        rd_ok = 1'b1;
        wr_ok = acc.priv;
      end
      mrp_pkg::MRP_PERM_RW_RW: begin
        rd_ok = 1'b1;
        wr_ok = 1'b1;
      end
      mrp_pkg::MRP_PERM_RO_NO: begin
        rd_ok = acc.priv;
      end
      mrp_pkg::MRP_PERM_RO_RO: begin
        rd_ok = 1'b1;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
    allowed = (acc.write ? wr_ok : rd_ok) && !(acc.fetch && region.exec_forbidden);
  end

endmodule

// ### rtl/mrp_apb_regs.sv
// apb slave holding global control and the eight region configurations
`timescale 1ns/1ps
module mrp_apb_regs #(
  parameter int unsigned REGIONS = mrp_pkg::MRP_REGIONS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] stat_word,
  input wire logic [31:0] fault_addr,
  output mrp_pkg::mrp_ctrl_t ctrl,
  output mrp_pkg::mrp_region_t [REGIONS-1:0] regions
);

  localparam int unsigned SELW = $clog2(REGIONS);

  mrp_pkg::mrp_ctrl_t ctrl_q, ctrl_d;
  mrp_pkg::mrp_region_t [REGIONS-1:0] rgn_q, rgn_d;
  logic [SELW-1:0] sel_q, sel_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_en;
  logic rd_en;
  logic known;
  mrp_pkg::mrp_region_t cur;
  logic [31:0] attr_word;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign ctrl = ctrl_q;
  assign regions = rgn_q;
  assign prdata = rdata_q;

  always_comb begin
    known = 1'b1;
    case (paddr)
      mrp_pkg::MRP_OFF_CTRL, mrp_pkg::MRP_OFF_COUNT, mrp_pkg::MRP_OFF_SELECT,
      mrp_pkg::MRP_OFF_BASE, mrp_pkg::MRP_OFF_ATTR, mrp_pkg::MRP_OFF_STATUS,
      mrp_pkg::MRP_OFF_FADDR: known = 1'b1;
      default: known = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !known;

  always_comb begin
    cur = rgn_q[sel_q];
    // readback packs attributes in the write layout
    attr_word = 32'h0000_0000;
    attr_word[mrp_pkg::MRP_ATTR_ACTIVE_BIT] = cur.active;
    attr_word[mrp_pkg::MRP_ATTR_SIZE_LSB +: 5] = cur.size;
    attr_word[mrp_pkg::MRP_ATTR_SUB_LSB +: 8] = cur.sub_off;
    attr_word[mrp_pkg::MRP_ATTR_PERM_LSB +: 3] = cur.perm;
    attr_word[mrp_pkg::MRP_ATTR_XN_BIT] = cur.exec_forbidden;
  end

  always_comb begin
    ctrl_d = ctrl_q;
    rgn_d = rgn_q;
    sel_d = sel_q;
    rdata_d = rdata_q;
    if (wr_en) begin
      case (paddr)
        mrp_pkg::MRP_OFF_CTRL: begin
          ctrl_d.enable = pwdata[mrp_pkg::MRP_CTRL_ENABLE_BIT];
          ctrl_d.privileged_default_map_option = pwdata[mrp_pkg::MRP_CTRL_PRIVDEF_BIT];
          ctrl_d.fault_handler_protect_option = pwdata[mrp_pkg::MRP_CTRL_HFNMI_BIT];
        end
        mrp_pkg::MRP_OFF_SELECT: sel_d = pwdata[SELW-1:0];
        mrp_pkg::MRP_OFF_BASE: rgn_d[sel_q].base = pwdata;
        mrp_pkg::MRP_OFF_ATTR: begin
          // enable bit written with the attributes
          rgn_d[sel_q].active = pwdata[mrp_pkg::MRP_ATTR_ACTIVE_BIT];
          // size codes below 32 bytes clamp to the smallest
          if (pwdata[mrp_pkg::MRP_ATTR_SIZE_LSB +: 5] < mrp_pkg::MRP_SIZE_MIN) begin
            rgn_d[sel_q].size = mrp_pkg::MRP_SIZE_MIN;
          end else begin
            rgn_d[sel_q].size = pwdata[mrp_pkg::MRP_ATTR_SIZE_LSB +: 5];
          end
          rgn_d[sel_q].sub_off = pwdata[mrp_pkg::MRP_ATTR_SUB_LSB +: 8];
          rgn_d[sel_q].perm = pwdata[mrp_pkg::MRP_ATTR_PERM_LSB +: 3];
          rgn_d[sel_q].exec_forbidden = pwdata[mrp_pkg::MRP_ATTR_XN_BIT];
        end
        default: begin
        end
      endcase
    end
    if (psel && !penable && !pwrite) begin
      case (paddr)
        mrp_pkg::MRP_OFF_CTRL: rdata_d = {29'h0, ctrl_q.fault_handler_protect_option,
                                          ctrl_q.privileged_default_map_option, ctrl_q.enable};
        mrp_pkg::MRP_OFF_COUNT: rdata_d = 32'(REGIONS);
        mrp_pkg::MRP_OFF_SELECT: rdata_d = 32'(sel_q);
        mrp_pkg::MRP_OFF_BASE: rdata_d = cur.base;
        mrp_pkg::MRP_OFF_ATTR: rdata_d = attr_word;
        mrp_pkg::MRP_OFF_STATUS: rdata_d = stat_word;
        mrp_pkg::MRP_OFF_FADDR: rdata_d = fault_addr;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
      sel_q <= '0;
      rdata_q <= 32'h0000_0000;
      for (int i = 0; i < REGIONS; i++) begin
        rgn_q[i] <= '{base: 32'h0000_0000, size: mrp_pkg::MRP_SIZE_RESET, sub_off: 8'h00,
                      perm: mrp_pkg::MRP_PERM_NO_NO, exec_forbidden: 1'b0, active: 1'b0};
      end
    end else begin
      ctrl_q <= ctrl_d;
      rgn_q <= rgn_d;
      sel_q <= sel_d;
      rdata_q <= rdata_d;
    end
  end

  logic unused_rd;
  assign unused_rd = rd_en;

endmodule

// ### rtl/mrp_top.sv
// memory region protection unit: access checker with apb configuration
`timescale 1ns/1ps
module mrp_top #(
  parameter int unsigned REGIONS = mrp_pkg::MRP_REGIONS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mrp_pkg::mrp_access_t acc,
  output logic fault,
  output logic use_default_map,
  output logic [2:0] hit_region
);

  // hit_region is three bits wide and the select register needs at least one bit
  if (REGIONS < 2 || REGIONS > 8) begin : g_bad_regions
    $error("REGIONS must be 2..8");
  end

  mrp_pkg::mrp_ctrl_t ctrl;
  mrp_pkg::mrp_region_t [REGIONS-1:0] regions;
  logic [REGIONS-1:0] hit;
  logic [REGIONS-1:0] allowed;
  mrp_pkg::mrp_result_t res;
  logic win_ok;
  logic any_hit;
  logic [2:0] win;
  logic checking;
  logic fault_q, fault_d;
  logic dflt_q, dflt_d;
  logic [2:0] win_q, win_d;
  logic sticky_q, sticky_d;
  logic [31:0] faddr_q, faddr_d;

  mrp_apb_regs #(.REGIONS(REGIONS)) u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .stat_word({28'h0, win_q, sticky_q}),
    .fault_addr(faddr_q),
    .ctrl(ctrl),
    .regions(regions)
  );

  for (genvar g = 0; g < REGIONS; g++) begin : g_rgn
    mrp_region_match u_match (
      .region(regions[g]),
      .acc(acc),
      .hit(hit[g]),
      .allowed(allowed[g])
    );
  end

  always_comb begin
    any_hit = 1'b0;
    win = 3'h0;
    win_ok = 1'b0;
    for (int i = 0; i < REGIONS; i++) begin
      if (hit[i]) begin
        any_hit = 1'b1;
        win = 3'(i);
        win_ok = allowed[i];
      end
    end
    // handlers bypass checks unless option set
    checking = ctrl.enable && !(acc.handler && !ctrl.fault_handler_protect_option);
    if (!checking) begin
      // off means default map, never fault
      res = mrp_pkg::MRP_RES_DEFAULT;
    end else if (any_hit) begin
      res = win_ok ? mrp_pkg::MRP_RES_REGION : mrp_pkg::MRP_RES_FAULT;
    end else if (acc.priv && ctrl.privileged_default_map_option) begin
      // privileged miss falls back to default map
      res = mrp_pkg::MRP_RES_DEFAULT;
    end else begin
      res = mrp_pkg::MRP_RES_FAULT;
    end
  end

  always_comb begin
    fault_d = 1'b0;
    dflt_d = dflt_q;
    win_d = win_q;
    sticky_d = sticky_q;
    faddr_d = faddr_q;
    if (acc.valid) begin
      fault_d = (res == mrp_pkg::MRP_RES_FAULT);
      dflt_d = (res == mrp_pkg::MRP_RES_DEFAULT);
      win_d = win;
    end
    // sticky record of the first fault; cleared by reading nothing, held for software
    if (acc.valid && res == mrp_pkg::MRP_RES_FAULT && !sticky_q) begin
      sticky_d = 1'b1;
      faddr_d = acc.addr;
    end
    if (psel && penable && pwrite && paddr == mrp_pkg::MRP_OFF_STATUS && pwdata[0]) begin
      // a new fault in the same cycle wins over the clear
      sticky_d = fault_d;
      if (fault_d) begin
        faddr_d = acc.addr;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= 1'b0;
      dflt_q <= 1'b1;
      win_q <= 3'h0;
      sticky_q <= 1'b0;
      faddr_q <= 32'h0000_0000;
    end else begin
      fault_q <= fault_d;
      dflt_q <= dflt_d;
      win_q <= win_d;
      sticky_q <= sticky_d;
      faddr_q <= faddr_d;
    end
  end

  // verdict is registered: one cycle after the access is presented
  assign fault = fault_q;
  assign use_default_map = dflt_q;
  assign hit_region = win_q;

endmodule

// ### bench/mrp_core_model.sv
// processor core model issuing one checked memory access at a time
`timescale 1ns/1ps
module mrp_core_model (
  input wire logic pclk,
  output mrp_pkg::mrp_access_t acc
);
  initial acc = '0;
  // k is write, fetch, priv, handler; the address is scrambled once released
  task automatic issue(input logic [31:0] a, input logic [3:0] k);
    @(posedge pclk);
    acc <= {1'b1, a, k};
    @(posedge pclk);
    acc <= {1'b0, ~a, ~k};
  endtask
endmodule

// ### bench/mrp_top_monitor.sv
// concurrent checks on the ports of the protection unit
`timescale 1ns/1ps
module mrp_top_monitor #(
  parameter int unsigned REGIONS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire mrp_pkg::mrp_access_t acc,
  input wire logic fault,
  input wire logic use_default_map,
  input wire logic [2:0] hit_region
);
  // shadow of the control word, seen only through bus writes
  logic [2:0] cfg_q;
  logic [2:0] cfg_d;
  always_comb begin
    cfg_d = cfg_q;
    if (psel && penable && pwrite && paddr == mrp_pkg::MRP_OFF_CTRL) begin
      cfg_d = pwdata[2:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= 3'h0;
    end else begin
      cfg_q <= cfg_d;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_count_setup;
    psel && !penable && !pwrite && paddr == mrp_pkg::MRP_OFF_COUNT;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  chk_count_value: assert property (s_count_setup ##1 s_access |-> prdata == REGIONS)
    else $error("region count read wrong");
  chk_ready_high: assert property (s_access |-> pready)
    else $error("ready low in access phase");
  chk_unmapped_err: assert property ((s_access and (paddr > mrp_pkg::MRP_OFF_FADDR))
    |-> pslverr)
    else $error("no error on unmapped address");
  chk_off_quiet: assert property (acc.valid && !cfg_q[0] |=> !fault && use_default_map)
    else $error("check active while protection off");
  chk_handler_map: assert property (acc.valid && acc.handler && cfg_q[0] && !cfg_q[2]
    |=> !fault && use_default_map)
    else $error("handler access not on default map");
  chk_fault_cause: assert property (!acc.valid |=> !fault)
    else $error("fault without an access");
  chk_fault_excl: assert property (fault |-> !use_default_map)
    else $error("fault while default map applied");
  chk_verdict_hold: assert property (!acc.valid |=> $stable(use_default_map)
    && $stable(hit_region))
    else $error("verdict changed without access");
endmodule
bind mrp_top mrp_top_monitor #(.REGIONS(REGIONS)) u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .acc(acc), .fault(fault),
  .use_default_map(use_default_map), .hit_region(hit_region));

// ### bench/test_mrp_top.sv
// self-checking bench for the memory region protection unit
`timescale 1ns/1ps
module test_mrp_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  mrp_pkg::mrp_access_t acc;
  logic fault;
  logic use_default_map;
  logic [2:0] hit_region;
  int err_total = 0;
  int comparisons = 0;
  logic [31:0] q;
  logic e;
  localparam logic [31:0] RB = 32'h2000_0000;
  localparam logic [3:0] UR = 4'h0;
  localparam logic [3:0] UW = 4'h8;
  localparam logic [3:0] PR = 4'h2;
  localparam logic [3:0] PF = 4'h6;
  localparam logic [3:0] PH = 4'h3;
  logic [2:0] pc [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
  // allowed: priv read, priv write, user read, user write
  logic [3:0] ok [6] = '{4'h0, 4'hC, 4'hE, 4'hF, 4'h8, 4'hA};

  mrp_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .acc(acc), .fault(fault), .use_default_map(use_default_map),
    .hit_region(hit_region));
  mrp_core_model core (.pclk(pclk), .acc(acc));

  initial begin
    forever #5 pclk = ~pclk;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_total++;
      give_verdict();
    end
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] v;
    logic er;
    // own locals so that a write never overwrites a value the caller still holds
    apb(1'b1, a, d, v, er);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] v;
    logic er;
    apb(1'b0, a, 32'h0, v, er);
    cmp("read data", x, v);
  endtask

  function automatic logic [31:0] at(input logic [4:0] s, input logic [7:0] sb,
    input logic [2:0] p, input logic x, input logic a);
    at = {3'h0, x, 1'h0, p, 8'h00, sb, 2'h0, s, a};
  endfunction

  task automatic setr(input logic [31:0] i, input logic [31:0] b, input logic [31:0] t);
    wr(mrp_pkg::MRP_OFF_SELECT, i);
    wr(mrp_pkg::MRP_OFF_BASE, b);
    wr(mrp_pkg::MRP_OFF_ATTR, t);
  endtask

  task automatic chk_acc(input logic [31:0] a, input logic [3:0] k, input logic f,
    input logic d, input logic [2:0] h);
    core.issue(a, k);
    #1;
    cmp("fault", f, fault);
    cmp("default map", d, use_default_map);
    if (!d) cmp("hit region", h, hit_region);
  endtask

  initial begin
    #900000;
    err_total++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(mrp_pkg::MRP_OFF_COUNT, mrp_pkg::MRP_REGIONS);
    rd(mrp_pkg::MRP_OFF_CTRL, 32'h0);
    wr(mrp_pkg::MRP_OFF_SELECT, 32'h7);
    rd(mrp_pkg::MRP_OFF_ATTR, at(5'h04, 8'h00, 3'h0, 1'b0, 1'b0));
    apb(1'b0, 12'h01C, 32'h0, q, e);
    cmp("unmapped error", 1'b1, e);
    $display("test reset finished");
    chk_acc(RB, UR, 1'b0, 1'b1, 3'h0);
    wr(mrp_pkg::MRP_OFF_CTRL, 32'h1);
    chk_acc(RB, PR, 1'b1, 1'b0, 3'h0);
    rd(mrp_pkg::MRP_OFF_FADDR, RB);
    rd(mrp_pkg::MRP_OFF_STATUS, 32'h1);
    wr(mrp_pkg::MRP_OFF_STATUS, 32'h1);
    rd(mrp_pkg::MRP_OFF_STATUS, 32'h0);
    wr(mrp_pkg::MRP_OFF_CTRL, 32'h3);
    chk_acc(RB, PR, 1'b0, 1'b1, 3'h0);
    chk_acc(RB, UR, 1'b1, 1'b0, 3'h0);
    wr(mrp_pkg::MRP_OFF_CTRL, 32'h1);
    for (int i = 0; i < 6; i++) begin
      setr(0, RB, at(5'd11, 8'h00, pc[i], 1'b0, 1'b1));
      for (int j = 0; j < 4; j++) begin
        chk_acc(RB + 32'h10, {j[0], 1'b0, ~j[1], 1'b0}, ~ok[i][3 - j], 1'b0, 3'h0);
      end
    end
    setr(0, RB, at(5'd11, 8'h00, 3'h3, 1'b1, 1'b1));
    chk_acc(RB, PF, 1'b1, 1'b0, 3'h0);
    chk_acc(RB, PR, 1'b0, 1'b0, 3'h0);
    $display("test permissions finished");
    setr(0, RB, at(5'd15, 8'h00, 3'h3, 1'b0, 1'b1));
    setr(1, RB, at(5'd11, 8'h04, 3'h0, 1'b0, 1'b1));
    setr(2, RB + 32'h2000, at(5'd6, 8'hFF, 3'h0, 1'b0, 1'b1));
    chk_acc(RB + 32'h400, PR, 1'b0, 1'b0, 3'h0);
    chk_acc(RB, PR, 1'b1, 1'b0, 3'h1);
    chk_acc(RB + 32'h2000, PR, 1'b1, 1'b0, 3'h2);
    wr(mrp_pkg::MRP_OFF_SELECT, 32'h1);
    apb(1'b0, mrp_pkg::MRP_OFF_ATTR, 32'h0, q, e);
    cmp("attr readback", at(5'd11, 8'h04, 3'h0, 1'b0, 1'b1), q);
    wr(mrp_pkg::MRP_OFF_ATTR, q & ~32'h1);
    chk_acc(RB, PR, 1'b0, 1'b0, 3'h0);
    rd(mrp_pkg::MRP_OFF_BASE, RB);
    wr(mrp_pkg::MRP_OFF_ATTR, q);
    chk_acc(RB, PR, 1'b1, 1'b0, 3'h1);
    $display("test regions finished");
    chk_acc(RB, PH, 1'b0, 1'b1, 3'h0);
    wr(mrp_pkg::MRP_OFF_CTRL, 32'h5);
    chk_acc(RB, PH, 1'b1, 1'b0, 3'h1);
    wr(mrp_pkg::MRP_OFF_CTRL, 32'h0);
    chk_acc(RB, UW, 1'b0, 1'b1, 3'h0);
    $display("test options finished");
    give_verdict();
  end
endmodule
